// ### hdl/dbp_probe_ctrl.sv
// Back-power probe sequencer: probes the bus, watches for the stream, applies full power.
// Assumes comparator and PD status pins are asynchronous and supply switches are external.
`timescale 1ns/10ps
module dbp_probe_ctrl (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic resetn_i,
    // Bus sensing, asynchronous comparators
    input wire logic bus_above_off_i,
    input wire logic bus_full_power_i,
    input wire logic partner_detect_i,
    input wire logic partner_detect_en_i,
    // PD link state, asynchronous
    input wire logic pd_connected_i,
    input wire logic hard_reset_i,
    input wire logic detached_i,
    // Received bit stream, same clock domain
    input wire logic rx_valid_i,
    input wire logic rx_bit_i,
    // Timer lengths in cycles
    input wire logic [dbp_pkg::CNT_W-1:0] probe_interval_cyc_i,
    input wire logic [dbp_pkg::CNT_W-1:0] stream_wait_cyc_i,
    input wire logic [dbp_pkg::CNT_W-1:0] discharge_cyc_i,
    input wire logic [dbp_pkg::CNT_W-1:0] retry_delay_cyc_i,
    input wire logic [dbp_pkg::CNT_W-1:0] sink_ready_cyc_i,
    // Supply control and status
    output logic probe_supply_en_o,
    output logic full_power_en_o,
    output logic discharge_en_o,
    output logic sink_role_o,
    output logic pd_active_o,
    output logic sink_ready_fail_o,
    output logic [2:0] state_o
);
    import dbp_pkg::*;

    // ****************************************
    // Synchronisers
    // ****************************************
    localparam int NSYNC = 7;
    logic [NSYNC-1:0] raw;
    logic [NSYNC-1:0] meta_q;
    logic [NSYNC-1:0] sync_q;

    assign raw = {bus_above_off_i, bus_full_power_i, partner_detect_i, partner_detect_en_i,
                  pd_connected_i, hard_reset_i, detached_i};

    genvar g;
    generate
        for (g = 0; g < NSYNC; g++) begin : g_sync
            always_ff @(posedge core_clk_i) begin
                if (!resetn_i) begin
                    meta_q[g] <= 1'b0;
                    sync_q[g] <= 1'b0;
                end else begin
                    meta_q[g] <= raw[g];
                    sync_q[g] <= meta_q[g];
                end
            end
        end
    endgenerate

    logic above_off;
    logic full_seen;
    logic partner_seen;
    logic partner_gate;
    logic pd_conn;
    logic hard_rst;
    logic detach;
    assign {above_off, full_seen, partner_seen, partner_gate, pd_conn, hard_rst, detach} = sync_q;

    // ****************************************
    // Stream detector
    // ****************************************
    dbp_stream_if sif ();

    dbp_stream_det u_det (
        .core_clk_i(core_clk_i),
        .resetn_i(resetn_i),
        .rx_valid_i(rx_valid_i),
        .rx_bit_i(rx_bit_i),
        .link(sif.det)
    );

    // ****************************************
    // Sequencer
    // ****************************************
    typedef struct packed {
        dbp_state_t st;
        logic [CNT_W-1:0] tmr;
        logic [CNT_W-1:0] retry;
        logic pd_seen;
        logic probe_en;
        logic full_en;
        logic dis_en;
        logic sink;
        logic active;
        logic fail;
        logic det_clr;
    } dbp_ctl_st_t;

    dbp_ctl_st_t s_q;
    dbp_ctl_st_t s_d;

    function automatic logic expired(input logic [CNT_W-1:0] t, input logic [CNT_W-1:0] lim);
        expired = (t + 32'h0000_0001) >= lim;
    endfunction

    always_comb begin
        s_d = s_q;
        s_d.tmr = s_q.tmr + 32'h0000_0001;
        s_d.det_clr = 1'b0;
        if ((s_q.st == DBP_DISCHARGE) || (s_q.st == DBP_SINK_READY_FAIL)) begin
            s_d.retry = s_q.retry + 32'h0000_0001;
        end
        if (hard_rst || detach) begin
            // PD mode kept until detach, hard reset or lost PD connection
            s_d.st = DBP_IDLE;
            s_d.pd_seen = 1'b0;
        end else if (s_q.pd_seen && !pd_conn) begin
            s_d.st = DBP_IDLE;
            s_d.pd_seen = 1'b0;
        end else begin
            if (pd_conn) begin
                s_d.pd_seen = 1'b1;
            end
            unique case (s_q.st)
                DBP_IDLE: begin
                    s_d.st = DBP_WAIT_PROBE;
                    s_d.tmr = CNT_RST;
                    s_d.det_clr = 1'b1;
                end
                DBP_WAIT_PROBE: begin
                    if (above_off || full_seen) begin
                        s_d.st = DBP_SINK;
                    end else if (expired(s_q.tmr, probe_interval_cyc_i)
                                 && (!partner_gate || partner_seen)) begin
                        s_d.st = DBP_PROBE;
                        s_d.tmr = CNT_RST;
                        s_d.det_clr = 1'b1;
                    end
                end
                DBP_PROBE: begin
                    if (sif.found) begin
                        s_d.st = DBP_FULL_POWER;
                        s_d.tmr = CNT_RST;
                        s_d.retry = CNT_RST;
                    end else if (expired(s_q.tmr, stream_wait_cyc_i)) begin
                        s_d.st = DBP_DISCHARGE;
                        s_d.tmr = CNT_RST;
                        s_d.retry = CNT_RST;
                    end
                end
                DBP_DISCHARGE: begin
                    if (expired(s_q.retry, retry_delay_cyc_i)) begin
                        s_d.st = DBP_IDLE;
                    end
                end
                DBP_FULL_POWER: begin
                    // Partner must go quiet in time
                    if (expired(s_q.retry, QUIET_CYC)) begin
                        s_d.st = DBP_PD_ACTIVE;
                    end else if (expired(s_q.tmr, sink_ready_cyc_i)) begin
                        s_d.st = DBP_SINK_READY_FAIL;
                        s_d.tmr = CNT_RST;
                        s_d.retry = CNT_RST;
                    end else begin
                        // Quiet run restarts on every bit, so only a gap of QUIET_CYC cycles in a live stream ends it
                        s_d.retry = rx_valid_i ? CNT_RST : s_q.retry + 32'h0000_0001;
                    end
                end
                DBP_SINK_READY_FAIL: begin
                    // Partner never got ready: drop power and retry
                    if (expired(s_q.retry, retry_delay_cyc_i)) begin
                        s_d.st = DBP_IDLE;
                    end
                end
                DBP_SINK: begin
                    if (!above_off && !full_seen && !s_q.pd_seen) begin
                        s_d.st = DBP_IDLE;
                    end
                end
                DBP_PD_ACTIVE: begin
                end
            endcase
        end
        s_d.probe_en = (s_d.st == DBP_PROBE);
        s_d.full_en = (s_d.st == DBP_FULL_POWER) || (s_d.st == DBP_PD_ACTIVE);
        s_d.dis_en = ((s_d.st == DBP_DISCHARGE) || (s_d.st == DBP_SINK_READY_FAIL))
                     && (s_d.retry < discharge_cyc_i);
        s_d.sink = (s_d.st == DBP_SINK);
        s_d.active = (s_d.st == DBP_PD_ACTIVE);
        s_d.fail = (s_d.st == DBP_SINK_READY_FAIL);
    end

    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            s_q <= '{st: DBP_IDLE, tmr: CNT_RST, retry: CNT_RST, pd_seen: 1'b0,
                     probe_en: 1'b0, full_en: 1'b0, dis_en: 1'b0, sink: 1'b0,
                     active: 1'b0, fail: 1'b0, det_clr: 1'b1};
        end else begin
            s_q <= s_d;
        end
    end

    assign sif.clear = s_q.det_clr;
    assign probe_supply_en_o = s_q.probe_en;
    assign full_power_en_o = s_q.full_en;
    assign discharge_en_o = s_q.dis_en;
    assign sink_role_o = s_q.sink;
    assign pd_active_o = s_q.active;
    assign sink_ready_fail_o = s_q.fail;
    assign state_o = s_q.st;
endmodule

// ### hdl/dbp_pkg.sv
// Constants and states for the back-power probe sequencer.
// Assumes one 250 MHz controller clock and analog comparators behind plain pins.
// Functional notes
// - Keep PD behaviour until detach or reset
// - Lost PD connection returns to default
// - Probe periodically while full power absent
// - Stream detected: apply full bus power
// - No stream: no full power, keep probing
// - Probe current, power and duration bounded
// - Optional other partner detection first
// - Dead-partner detection always implemented
// - Initial step starts probe interval timer
// - Bus above off level: become sink
// - Timer expiry: probe supply, stream wait
// - Stream needs 128 alternating bits
// - Timeout: discharge, retry delay, restart
// - Detection: full power, sink-ready timer
package dbp_pkg;
    localparam int CLK_MHZ = 250;
    localparam int CNT_W = 32;
    // Default durations in microseconds
    localparam int PROBE_INTERVAL_US = 100_000;
    localparam int STREAM_WAIT_US = 50_000;
    localparam int DISCHARGE_US = 10_000;
    localparam int RETRY_DELAY_US = 20_000;
    localparam int SINK_READY_US = 500_000;
    localparam logic [CNT_W-1:0] PROBE_INTERVAL_CYC = CNT_W'(PROBE_INTERVAL_US * CLK_MHZ);
    localparam logic [CNT_W-1:0] STREAM_WAIT_CYC = CNT_W'(STREAM_WAIT_US * CLK_MHZ);
    localparam logic [CNT_W-1:0] DISCHARGE_CYC = CNT_W'(DISCHARGE_US * CLK_MHZ);
    localparam logic [CNT_W-1:0] RETRY_DELAY_CYC = CNT_W'(RETRY_DELAY_US * CLK_MHZ);
    localparam logic [CNT_W-1:0] SINK_READY_CYC = CNT_W'(SINK_READY_US * CLK_MHZ);
    localparam int STREAM_BITS = 128;
    localparam int BIT_CNT_W = 8;
    localparam logic [BIT_CNT_W-1:0] BIT_CNT_RST = 8'h00;
    localparam logic [CNT_W-1:0] CNT_RST = 32'h0000_0000;
    // Quiet cycles after which the stream counts as stopped
    localparam logic [CNT_W-1:0] QUIET_CYC = 32'h0000_0100;

    typedef enum logic [2:0] {
        DBP_IDLE,
        DBP_WAIT_PROBE,
        DBP_PROBE,
        DBP_DISCHARGE,
        DBP_FULL_POWER,
        DBP_SINK_READY_FAIL,
        DBP_SINK,
        DBP_PD_ACTIVE
    } dbp_state_t;
endpackage

// ### hdl/dbp_stream_if.sv
// Carries the bit-stream detector request and result between modules.
// Assumes both ends share core_clk_i.
`timescale 1ns/10ps
interface dbp_stream_if;
    logic clear;
    logic found;
    modport ctrl (output clear, input found);
    modport det (input clear, output found);
endinterface

// ### hdl/dbp_stream_det.sv
// Alternating-bit stream detector on the received PD data bit.
// Assumes rx_bit_i and rx_valid_i are already synchronous to core_clk_i.
`timescale 1ns/10ps
module dbp_stream_det (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic resetn_i,
    // Received bits
    input wire logic rx_valid_i,
    input wire logic rx_bit_i,
    // Controller side
    dbp_stream_if.det link
);
    import dbp_pkg::*;

    typedef struct packed {
        logic [BIT_CNT_W-1:0] cnt;
        logic last;
        logic found;
    } dbp_det_st_t;

    dbp_det_st_t s_q;
    dbp_det_st_t s_d;

    always_comb begin
        s_d = s_q;
        if (link.clear) begin
            s_d = '{cnt: BIT_CNT_RST, last: 1'b0, found: 1'b0};
        end else if (rx_valid_i && !s_q.found) begin
            if (s_q.cnt == BIT_CNT_RST || rx_bit_i != s_q.last) begin
                s_d.cnt = s_q.cnt + 8'h01;
            end else begin
                // Repeated bit restarts the run at one
                s_d.cnt = 8'h01;
            end
            s_d.last = rx_bit_i;
            if (s_d.cnt == BIT_CNT_W'(STREAM_BITS)) begin
                s_d.found = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            s_q <= '{cnt: BIT_CNT_RST, last: 1'b0, found: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign link.found = s_q.found;
endmodule

// ### verification/dbp_probe_ctrl_checker.sv
// Port assertions for the probe sequencer.
// Assumes one clock domain; bound in at the foot.
`timescale 1ns/10ps
module dbp_probe_ctrl_checker (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic resetn_i,
    // Inputs
    input wire logic bus_above_off_i,
    input wire logic rx_valid_i,
    input wire logic rx_bit_i,
    input wire logic [dbp_pkg::CNT_W-1:0] stream_wait_cyc_i,
    input wire logic [dbp_pkg::CNT_W-1:0] discharge_cyc_i,
    // Outputs
    input wire logic probe_supply_en_o,
    input wire logic full_power_en_o,
    input wire logic discharge_en_o,
    input wire logic sink_role_o,
    input wire logic [2:0] state_o
);
    import dbp_pkg::*;
    logic [CNT_W-1:0] dis_q;
    logic [CNT_W-1:0] prb_q;
    logic [7:0] run_q;
    logic last_q;
    // Own run counters, so bounds stay exact
    always_ff @(posedge core_clk_i) begin
        dis_q <= discharge_en_o ? dis_q + 1'b1 : '0;
        prb_q <= probe_supply_en_o ? prb_q + 1'b1 : '0;
        last_q <= rx_valid_i ? rx_bit_i : last_q;
        if (!resetn_i) begin
            run_q <= '0;
        end else if (rx_valid_i) begin
            run_q <= (run_q != '0 && rx_bit_i == last_q) ? 8'h01 : run_q + (run_q != 8'hff);
        end
    end
    // ************
    // Assertions
    // ************
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    property p_reset_off; disable iff (1'b0)
        !resetn_i |=> state_o == 3'h0 && !probe_supply_en_o && !full_power_en_o; endproperty
    a_reset_off: assert property (p_reset_off)
        else $error("not off after reset");
    property p_full_from_probe;
        $rose(full_power_en_o) |-> $past(probe_supply_en_o) && !probe_supply_en_o; endproperty
    a_full_from_probe: assert property (p_full_from_probe)
        else $error("full power not from probe");
    property p_one_supply; !(full_power_en_o && probe_supply_en_o)
        && !(discharge_en_o && (full_power_en_o || probe_supply_en_o)); endproperty
    a_one_supply: assert property (p_one_supply)
        else $error("supplies overlap");
    property p_probe_bounded; prb_q <= stream_wait_cyc_i + 1'b1; endproperty
    a_probe_bounded: assert property (p_probe_bounded)
        else $error("probe too long");
    property p_discharge_len; $fell(discharge_en_o) |-> dis_q == discharge_cyc_i; endproperty
    a_discharge_len: assert property (p_discharge_len)
        else $error("discharge length wrong");
    property p_stream_count; $rose(full_power_en_o) |-> run_q >= 8'h80; endproperty
    a_stream_count: assert property (p_stream_count)
        else $error("full power on short run");
    property p_sink_on_bus; (state_o == DBP_WAIT_PROBE && bus_above_off_i) [*2]
        |-> ##[0:2] sink_role_o; endproperty
    a_sink_on_bus: assert property (p_sink_on_bus)
        else $error("no sink on live bus");
    property p_sink_quiet; sink_role_o |-> !probe_supply_en_o && !full_power_en_o; endproperty
    a_sink_quiet: assert property (p_sink_quiet)
        else $error("sink drives bus");
    c_full: cover property ($rose(full_power_en_o));
    c_sink: cover property ($rose(sink_role_o));
    c_discharge: cover property ($rose(discharge_en_o));
endmodule
bind dbp_probe_ctrl dbp_probe_ctrl_checker u_checker (
    .core_clk_i, .resetn_i, .bus_above_off_i, .rx_valid_i, .rx_bit_i,
    .stream_wait_cyc_i, .discharge_cyc_i, .probe_supply_en_o, .full_power_en_o,
    .discharge_en_o, .sink_role_o, .state_o
);

// ### verification/dbp_partner_model.sv
// Far-side port with a dead battery.
// Assumes supply inputs come from the sequencer.
`timescale 1ns/10ps
module dbp_partner_model #(
    parameter int START_CYC = 20,
    parameter int READY_CYC = 100
) (
    // Clock and supply seen
    input wire logic core_clk_i,
    input wire logic probe_i,
    input wire logic full_i,
    // Behaviour set by the bench
    input wire logic want_i,
    input wire logic flaw_i,
    input wire logic hold_i,
    // Stream to the sequencer
    output logic rx_valid_o = 1'b0,
    output logic rx_bit_o = 1'b0
);
    int up_q = 0;
    int sent_q = 0;
    int full_q = 0;
    logic go;
    always @(negedge core_clk_i) begin
        go = up_q >= START_CYC && up_q % 2 == 1 && (hold_i || full_q < READY_CYC);
        if (!want_i || !(probe_i || full_i)) begin
            go = 1'b0;
            up_q <= 0;
            sent_q <= 0;
            full_q <= 0;
        end else begin
            up_q <= up_q + 1;
            full_q <= full_q + int'(full_i);
            sent_q <= sent_q + int'(go);
        end
        rx_valid_o <= go;
        // Flaw repeats one bit in a hundred; idle line toggles
        rx_bit_o <= go ? sent_q[0] ^ (flaw_i && sent_q % 100 == 99) : ~rx_bit_o;
    end
endmodule

// ### verification/test_dead_battery_backpower_probe.sv
// Self-checking bench for the probe sequencer.
// Assumes the partner model and bound checker are compiled too.
`timescale 1ns/10ps
module test_dead_battery_backpower_probe;
    import dbp_pkg::*;
    logic core_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic ext_bus = 1'b0, pdet = 1'b0, pd_up = 1'b0, hrst = 1'b0, want = 1'b0, flaw = 1'b0;
    logic hold = 1'b0, pden = 1'b0, dtch = 1'b0;
    logic rx_valid, rx_bit, prb, full, dis, snk, pda, srf, at_idle, at_wait;
    logic [2:0] st;
    logic [CNT_W-1:0] t_int, t_sw, t_dis, t_rt;
    logic [CNT_W-1:0] t_sr = 32'h0000_0bb8;
    int n_fail = 0;
    int n_compared = 0;
    int cyc = 0;
    int t0;
    always #2 core_clk_i = ~core_clk_i;
    always @(posedge core_clk_i) cyc <= cyc + 1;
    always_comb at_idle = (st === 3'h0);
    always_comb at_wait = (st === 3'h1);
    dbp_probe_ctrl uut (
        .core_clk_i, .resetn_i, .bus_above_off_i(prb | full | ext_bus),
        .bus_full_power_i(full), .partner_detect_i(pdet), .partner_detect_en_i(pden),
        .pd_connected_i(pd_up), .hard_reset_i(hrst), .detached_i(dtch),
        .rx_valid_i(rx_valid), .rx_bit_i(rx_bit), .probe_interval_cyc_i(t_int),
        .stream_wait_cyc_i(t_sw), .discharge_cyc_i(t_dis), .retry_delay_cyc_i(t_rt),
        .sink_ready_cyc_i(t_sr), .probe_supply_en_o(prb), .full_power_en_o(full),
        .discharge_en_o(dis), .sink_role_o(snk), .pd_active_o(pda),
        .sink_ready_fail_o(srf), .state_o(st)
    );
    dbp_partner_model u_partner (
        .core_clk_i, .probe_i(prb), .full_i(full), .want_i(want), .flaw_i(flaw),
        .hold_i(hold), .rx_valid_o(rx_valid), .rx_bit_o(rx_bit)
    );
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %0d seen %0d", what, exp, seen);
        end
    endtask
    task automatic wait_for(ref logic s, input logic lvl, input int lim);
        for (int k = 0; k < lim && s !== lvl; k++) @(negedge core_clk_i);
    endtask
    // Sync latency allowed either side
    function automatic logic near(input int seen, input logic [CNT_W-1:0] exp);
        return seen >= int'(exp) - 3 && seen <= int'(exp) + 3;
    endfunction
    task automatic tally_and_finish();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        #350_000;
        n_fail++;
        tally_and_finish();
    end
    initial begin
        void'($urandom(32'h19c8_590f));
        t_int = 32'($urandom_range(120, 60));
        t_sw = 32'($urandom_range(450, 400));
        t_dis = 32'($urandom_range(40, 20));
        t_rt = t_dis + 32'($urandom_range(60, 30));
        repeat (10) @(negedge core_clk_i);
        check("reset state", st, 3'h0);
        check("reset supplies", {prb, full, dis}, 3'h0);
        resetn_i = 1'b1;
        wait_for(at_wait, 1'b1, 4);
        t0 = cyc;
        check("wait after reset", at_wait, 1'b1);
        wait_for(prb, 1'b1, 300);
        check("probe interval", near(cyc - t0, t_int), 1'b1);
        wait_for(dis, 1'b1, int'(t_sw) + 10);
        t0 = cyc;
        check("silent partner", full, 1'b0);
        wait_for(dis, 1'b0, 200);
        check("discharge time", near(cyc - t0, t_dis), 1'b1);
        wait_for(at_idle, 1'b1, 200);
        check("retry delay", near(cyc - t0, t_rt), 1'b1);
        wait_for(prb, 1'b1, 300);
        check("probe repeats", prb, 1'b1);
        // Broken stream, then a good one
        want = 1'b1;
        flaw = 1'b1;
        wait_for(dis, 1'b1, 1000);
        check("flawed stream", full, 1'b0);
        flaw = 1'b0;
        wait_for(full, 1'b1, 2000);
        check("full power", full, 1'b1);
        check("probe off", prb, 1'b0);
        wait_for(pda, 1'b1, 3000);
        check("partner ready", pda, 1'b1);
        pd_up = 1'b1;
        repeat (10) @(negedge core_clk_i);
        pd_up = 1'b0;
        wait_for(full, 1'b0, 10);
        check("pd lost", full, 1'b0);
        // Partner never ready; hard reset first
        hold = 1'b1;
        wait_for(full, 1'b1, 2000);
        hrst = 1'b1;
        wait_for(full, 1'b0, 10);
        check("hard reset", full, 1'b0);
        hrst = 1'b0;
        wait_for(full, 1'b1, 2000);
        wait_for(srf, 1'b1, 2 * int'(t_sr) + 100);
        check("sink ready timeout", srf, 1'b1);
        hold = 1'b0;
        want = 1'b0;
        wait_for(at_wait, 1'b1, 2000);
        ext_bus = 1'b1;
        wait_for(snk, 1'b1, 8);
        check("live bus gives sink", snk, 1'b1);
        ext_bus = 1'b0;
        // Gate closed: interval runs out but no probe
        pden = 1'b1;
        wait_for(at_wait, 1'b1, 20);
        repeat (130) @(negedge core_clk_i);
        check("gate holds probe", prb, 1'b0);
        pdet = 1'b1;
        wait_for(prb, 1'b1, 8);
        check("gate opens probe", prb, 1'b1);
        dtch = 1'b1;
        wait_for(prb, 1'b0, 8);
        check("detach drops probe", {prb, st}, 4'h0);
        dtch = 1'b0;
        tally_and_finish();
    end
endmodule
